// >>> rtl/fetch_execute_pkg.sv
// Overview of operation
// (RULE1) The instruction clock comes from the primary oscillator pin in crystal mode or from the internal oscillator.
// (RULE2) The selected clock is divided by four into four non-overlapping phases that make one instruction cycle.
// (RULE3) The program counter steps once per instruction cycle, as phase one begins, which opens each fetch cycle.
// (RULE4) The fetched word enters the instruction latch at the edge into the execute cycle and runs in phases 2 to 4.
// (RULE5) The data operand is read in phase two and the destination is written in phase four of the same cycle.
// (RULE6) The next fetch overlaps the current execute, so straight-line instructions complete in one cycle.
// (RULE7) A program counter change costs two cycles: the fetched next word is dropped while the target is fetched.
// (RULE8) The program counter is 13 bits wide over an 8K space of 14-bit words.
// (RULE9) Only the low 4K words exist and any higher address wraps onto them.
// (RULE10) Reset starts at address zero and an interrupt loads the vector at address four.
// (RULE11) Vectors sit at 0000h-0004h, code page zero at 0005h-07FFh and code page one at 0800h-0FBFh.
// (RULE12) The top 64 words, 0FC0h-0FFFh, hold calibration data and are never run as code.
// (RULE13) The device is held in reset while master_clear_n is low, which the outside party drives.
// (RULE14) In internal mode the primary pin is a pulled-up button input that can interrupt; in crystal mode a clock in.
// (RULE15) In internal mode the secondary pin is a general output; in crystal mode it carries the clock output.
// (RULE16) A flushed slot writes nothing and behaves as a no-operation.
package fetch_execute_pkg;

	localparam int PC_W   = 13;
	localparam int IMPL_W = 12;
	localparam int WORD_W = 14;

	localparam logic [PC_W-1:0]   RESET_VEC   = 13'h0000;
	localparam logic [PC_W-1:0]   IRQ_VEC     = 13'h0004;
	localparam logic [IMPL_W-1:0] VEC_END     = 12'h004;
	localparam logic [IMPL_W-1:0] PAGE0_END   = 12'h7ff;
	localparam logic [IMPL_W-1:0] PAGE1_END   = 12'hfbf;
	localparam logic [PC_W-1:0]   PC_STEP     = 13'h0001;
	localparam logic [WORD_W-1:0] NOP_WORD    = 14'h0000;

	typedef enum logic [1:0]
	{
		PH_ONE   = 2'b00,
		PH_TWO   = 2'b01,
		PH_THREE = 2'b10,
		PH_FOUR  = 2'b11
	} phase_t;

	typedef enum logic [1:0]
	{
		REG_VECTOR = 2'b00,
		REG_PAGE0  = 2'b01,
		REG_PAGE1  = 2'b10,
		REG_CALIB  = 2'b11
	} region_t;

endpackage : fetch_execute_pkg

// >>> rtl/fetch_execute_sequencer.sv
`timescale 1ns/1ps
module fetch_execute_sequencer #(
	parameter int PC_W   = fetch_execute_pkg::PC_W,
	parameter int IMPL_W = fetch_execute_pkg::IMPL_W,
	parameter int WORD_W = fetch_execute_pkg::WORD_W
)(
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rstn,
	input  wire logic                  master_clear_n,
	// oscillator selection and pins
	input  wire logic                  crystal_osc_mode,
	input  wire logic                  internal_osc_tick,
	input  wire logic                  primary_osc_pin,
	input  wire logic                  gpio_out_level,
	output logic                       secondary_osc_pin,
	output logic                       push_button_input,
	output logic                       push_button_irq,
	// phase clocks
	output logic                       phase_one,
	output logic                       phase_two,
	output logic                       phase_three,
	output logic                       phase_four,
	// program memory
	output logic [IMPL_W-1:0]          prog_addr,
	input  wire logic [WORD_W-1:0]     prog_data,
	output fetch_execute_pkg::region_t fetch_region,
	output logic                       calib_fetch_blocked,
	// execute side
	output logic [WORD_W-1:0]          instruction_latch,
	output logic                       exec_valid,
	output logic                       operand_read_en,
	output logic                       dest_write_en,
	output logic [PC_W-1:0]            pc,
	input  wire logic                  branch_take,
	input  wire logic [PC_W-1:0]       branch_target,
	input  wire logic                  irq_request,
	output logic                       irq_ack
);

	typedef struct packed {
		fetch_execute_pkg::phase_t phase;
		logic [PC_W-1:0]           pc;
		logic [PC_W-1:0]           fetch_addr;
		logic                      fetch_ok;
		logic [WORD_W-1:0]         ir;
		logic                      exec_ok;
		logic                      osc_prev;
		logic                      btn_prev;
		logic                      btn_irq;
		logic                      irq_ack;
		logic                      clk_out;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic                 tick;
	logic                 at_q4_tick;
	logic                 branch_now;
	logic                 irq_take;
	logic [IMPL_W-1:0]    fetch_low;
	logic [PC_W-1:0]      next_fetch;
	logic                 next_calib;

	////////////////////////////////////////////////////////////////////////////////
	// clock source and phase stepping

	// the crystal clock is sampled, so it must run well below mclk/2
	always_comb
	begin
		if (crystal_osc_mode)
			tick = primary_osc_pin & ~s_q.osc_prev; // [RULE1]
		else
			tick = internal_osc_tick; // [RULE1]
	end

	assign at_q4_tick = tick && (s_q.phase == fetch_execute_pkg::PH_FOUR);
	assign branch_now = s_q.exec_ok && branch_take;
	assign irq_take   = irq_request && !branch_now;
	assign fetch_low  = s_q.fetch_addr[IMPL_W-1:0]; // [RULE9]

	always_comb
	begin
		if (branch_now)
			next_fetch = branch_target; // [RULE7]
		else if (irq_take)
			next_fetch = fetch_execute_pkg::IRQ_VEC; // [RULE10]
		else
			next_fetch = s_q.pc; // [RULE6]
	end

	// calibration words are data; a fetch there is refused as a no-op slot
	assign next_calib = next_fetch[IMPL_W-1:0] > fetch_execute_pkg::PAGE1_END; // [RULE12]

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		s_d          = s_q;
		s_d.osc_prev = primary_osc_pin;
		s_d.btn_prev = primary_osc_pin;
		s_d.btn_irq  = !crystal_osc_mode && s_q.btn_prev && !primary_osc_pin; // [RULE14]
		s_d.irq_ack  = 1'b0;
		if (tick)
		begin
			case (s_q.phase)
				fetch_execute_pkg::PH_ONE:   s_d.phase = fetch_execute_pkg::PH_TWO; // [RULE2]
				fetch_execute_pkg::PH_TWO:   s_d.phase = fetch_execute_pkg::PH_THREE;
				fetch_execute_pkg::PH_THREE: s_d.phase = fetch_execute_pkg::PH_FOUR;
				fetch_execute_pkg::PH_FOUR:  s_d.phase = fetch_execute_pkg::PH_ONE;
				default:                     s_d.phase = fetch_execute_pkg::PH_ONE;
			endcase
			s_d.clk_out = (s_d.phase == fetch_execute_pkg::PH_THREE) ||
				(s_d.phase == fetch_execute_pkg::PH_FOUR); // [RULE15]
		end
		if (at_q4_tick)
		begin
			s_d.ir         = prog_data; // [RULE4]
			s_d.exec_ok    = s_q.fetch_ok && !branch_now && !irq_take; // [RULE7] [RULE16]
			s_d.fetch_addr = next_fetch; // [RULE6]
			s_d.pc         = next_fetch + fetch_execute_pkg::PC_STEP; // [RULE3] [RULE8]
			s_d.fetch_ok   = !next_calib; // [RULE12]
			s_d.irq_ack    = irq_take; // [RULE10]
		end
		// synchronous hold while the master clear pin is low
		if (!master_clear_n)
		begin
			s_d.phase      = fetch_execute_pkg::PH_ONE; // [RULE13]
			s_d.pc         = fetch_execute_pkg::RESET_VEC + fetch_execute_pkg::PC_STEP; // [RULE10]
			s_d.fetch_addr = fetch_execute_pkg::RESET_VEC; // [RULE10]
			s_d.fetch_ok   = 1'b1;
			s_d.exec_ok    = 1'b0;
			s_d.ir         = fetch_execute_pkg::NOP_WORD;
			s_d.irq_ack    = 1'b0;
			s_d.clk_out    = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_q.phase      <= fetch_execute_pkg::PH_ONE;
			s_q.pc         <= fetch_execute_pkg::RESET_VEC + fetch_execute_pkg::PC_STEP; // [RULE10]
			s_q.fetch_addr <= fetch_execute_pkg::RESET_VEC;
			s_q.fetch_ok   <= 1'b1;
			s_q.ir         <= fetch_execute_pkg::NOP_WORD;
			s_q.exec_ok    <= 1'b0;
			s_q.osc_prev   <= 1'b0;
			s_q.btn_prev   <= 1'b1;
			s_q.btn_irq    <= 1'b0;
			s_q.irq_ack    <= 1'b0;
			s_q.clk_out    <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign phase_one   = s_q.phase == fetch_execute_pkg::PH_ONE; // [RULE2]
	assign phase_two   = s_q.phase == fetch_execute_pkg::PH_TWO;
	assign phase_three = s_q.phase == fetch_execute_pkg::PH_THREE;
	assign phase_four  = s_q.phase == fetch_execute_pkg::PH_FOUR;

	assign prog_addr           = fetch_low; // [RULE9]
	assign calib_fetch_blocked = !s_q.fetch_ok;
	assign instruction_latch   = s_q.ir;
	assign exec_valid          = s_q.exec_ok;
	assign pc                  = s_q.pc;
	assign irq_ack             = s_q.irq_ack;
	assign push_button_irq     = s_q.btn_irq;

	// the slot of a flushed word raises neither strobe
	assign operand_read_en = phase_two && s_q.exec_ok; // [RULE5] [RULE16]
	assign dest_write_en   = phase_four && s_q.exec_ok; // [RULE5] [RULE16]

	// button reads as released (pulled up) while the pin is a clock
	assign push_button_input = crystal_osc_mode ? 1'b1 : primary_osc_pin; // [RULE14]
	assign secondary_osc_pin = crystal_osc_mode ? s_q.clk_out : gpio_out_level; // [RULE15]

	always_comb
	begin
		if (fetch_low <= fetch_execute_pkg::VEC_END)
			fetch_region = fetch_execute_pkg::REG_VECTOR; // [RULE11]
		else if (fetch_low <= fetch_execute_pkg::PAGE0_END)
			fetch_region = fetch_execute_pkg::REG_PAGE0; // [RULE11]
		else if (fetch_low <= fetch_execute_pkg::PAGE1_END)
			fetch_region = fetch_execute_pkg::REG_PAGE1; // [RULE11]
		else
			fetch_region = fetch_execute_pkg::REG_CALIB; // [RULE12]
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	sequence seq_q4_tick;
		tick && phase_four && master_clear_n;
	endsequence

	sequence seq_branch;
		seq_q4_tick ##0 branch_now;
	endsequence

	sequence seq_straight;
		seq_q4_tick ##0 !branch_now ##0 !irq_take;
	endsequence

	// pin high then low while it serves as the button
	sequence seq_btn_fall;
		!crystal_osc_mode && primary_osc_pin ##1 !crystal_osc_mode && !primary_osc_pin;
	endsequence

	a_phase_order: assert property (@(posedge mclk) disable iff (!rstn) // [RULE2]
		(tick && phase_one && master_clear_n) |=> phase_two && !phase_one)
		else $error("phase two did not follow phase one");

	a_phase_hold: assert property (@(posedge mclk) disable iff (!rstn) // [RULE2]
		(!tick && master_clear_n) |=> $stable(s_q.phase))
		else $error("phase moved without a clock tick");

	a_pc_step: assert property (@(posedge mclk) disable iff (!rstn) // [RULE3]
		seq_straight |=> phase_one && pc == $past(pc) + fetch_execute_pkg::PC_STEP)
		else $error("program counter did not step by one");

	a_ir_load: assert property (@(posedge mclk) disable iff (!rstn) // [RULE4]
		seq_q4_tick |=> instruction_latch == $past(prog_data))
		else $error("instruction latch missed the fetched word");

	a_strobe_phases: assert property (@(posedge mclk) disable iff (!rstn) // [RULE5]
		(operand_read_en |-> phase_two && exec_valid) and (dest_write_en |-> phase_four && exec_valid))
		else $error("operand strobe outside its phase");

	a_overlap_run: assert property (@(posedge mclk) disable iff (!rstn) // [RULE6]
		(seq_straight ##0 !calib_fetch_blocked) |=> exec_valid && prog_addr == $past(pc[IMPL_W-1:0]))
		else $error("straight-line word not executed next cycle");

	a_branch_flush: assert property (@(posedge mclk) disable iff (!rstn) // [RULE7]
		seq_branch |=> !exec_valid && !dest_write_en && s_q.fetch_addr == $past(branch_target))
		else $error("branch did not flush and redirect");

	a_irq_vector: assert property (@(posedge mclk) disable iff (!rstn) // [RULE10]
		(seq_q4_tick ##0 irq_take) |=> irq_ack && s_q.fetch_addr == fetch_execute_pkg::IRQ_VEC)
		else $error("interrupt vector not loaded");

	a_master_clear_n_hold: assert property (@(posedge mclk) disable iff (!rstn) // [RULE13]
		!master_clear_n |=> phase_one && s_q.fetch_addr == fetch_execute_pkg::RESET_VEC && !exec_valid)
		else $error("master clear did not hold reset state");

	a_calib_block: assert property (@(posedge mclk) disable iff (!rstn) // [RULE12]
		(fetch_region == fetch_execute_pkg::REG_CALIB) |-> calib_fetch_blocked)
		else $error("calibration word accepted as code");

	a_clock_out_pin_pin: assert property (@(posedge mclk) disable iff (!rstn) // [RULE15]
		crystal_osc_mode |-> secondary_osc_pin == (phase_three || phase_four))
		else $error("clock output does not follow the phases");

	a_gpio_pin: assert property (@(posedge mclk) disable iff (!rstn) // [RULE15]
		!crystal_osc_mode |-> secondary_osc_pin == gpio_out_level)
		else $error("secondary pin does not carry the output level");

	a_phase_two_three: assert property (@(posedge mclk) disable iff (!rstn) // [RULE2]
		(tick && phase_two && master_clear_n) |=> phase_three)
		else $error("phase three did not follow phase two");

	a_phase_three_four: assert property (@(posedge mclk) disable iff (!rstn) // [RULE2]
		(tick && phase_three && master_clear_n) |=> phase_four)
		else $error("phase four did not follow phase three");

	a_phase_wrap: assert property (@(posedge mclk) disable iff (!rstn) // [RULE2]
		(tick && phase_four && master_clear_n) |=> phase_one)
		else $error("phase one did not follow phase four");

	a_osc_internal: assert property (@(posedge mclk) disable iff (!rstn) // [RULE1]
		(!crystal_osc_mode && internal_osc_tick && phase_one && master_clear_n) |=> phase_two)
		else $error("internal oscillator tick not taken");

	a_osc_crystal: assert property (@(posedge mclk) disable iff (!rstn) // [RULE1]
		(crystal_osc_mode && !primary_osc_pin && master_clear_n) |=> $stable(s_q.phase))
		else $error("phase moved with the crystal pin low");

	a_pc_idle: assert property (@(posedge mclk) disable iff (!rstn) // [RULE3]
		(!at_q4_tick && master_clear_n) |=> $stable(pc) && $stable(instruction_latch))
		else $error("program counter or latch moved between fetches");

	a_branch_pc: assert property (@(posedge mclk) disable iff (!rstn) // [RULE7]
		seq_branch |=> pc == $past(branch_target) + fetch_execute_pkg::PC_STEP)
		else $error("program counter not past the branch target");

	a_wrap_addr: assert property (@(posedge mclk) disable iff (!rstn) // [RULE9]
		seq_branch |=> prog_addr == $past(branch_target[IMPL_W-1:0]))
		else $error("fetch address did not wrap onto the low words");

	a_irq_pulse: assert property (@(posedge mclk) disable iff (!rstn) // [RULE10]
		irq_ack |=> !irq_ack)
		else $error("interrupt acknowledge longer than one cycle");

	a_irq_flush: assert property (@(posedge mclk) disable iff (!rstn) // [RULE16]
		(seq_q4_tick ##0 irq_take) |=> !exec_valid && !operand_read_en)
		else $error("interrupt did not flush the fetched word");

	a_btn_irq_edge: assert property (@(posedge mclk) disable iff (!rstn) // [RULE14]
		seq_btn_fall |=> push_button_irq)
		else $error("button press raised no interrupt");

	a_btn_irq_mode: assert property (@(posedge mclk) disable iff (!rstn) // [RULE14]
		crystal_osc_mode |=> !push_button_irq)
		else $error("button interrupt while the pin is a clock");

endmodule : fetch_execute_sequencer

// >>> sim/prog_memory_model.sv
`timescale 1ns/1ps
module prog_memory_model (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	// program memory
	input  wire logic [11:0] prog_addr,
	output logic      [13:0] prog_data,
	// clock sources
	output logic             osc_tick,
	output logic             osc_wave
);
	logic [1:0] div_q;

	// each word carries its own address, so a misfetch shows up in the latch
	assign prog_data = {2'b01, prog_addr};

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			div_q <= 2'h0;
		else
			div_q <= div_q + 2'h1;
	end

	// internal source ticks every other cycle; the crystal wave uses the 4-cycle period, the fastest allowed
	assign osc_tick = div_q[0];
	assign osc_wave = div_q[1];
endmodule : prog_memory_model

// >>> sim/test_fetch_execute_sequencer.sv
`timescale 1ns/1ps
module test_fetch_execute_sequencer;
	logic        mclk, rstn, master_clear_n, crystal_osc_mode, internal_osc_tick, primary_osc_pin, gpio_out_level;
	logic        secondary_osc_pin, push_button_input, push_button_irq, phase_one, phase_two, phase_three, phase_four;
	logic        calib_fetch_blocked, exec_valid, operand_read_en, dest_write_en, branch_take, irq_request, irq_ack;
	logic        btn, osc_wave;
	logic [11:0] prog_addr;
	logic [13:0] prog_data, instruction_latch;
	logic [12:0] pc, branch_target;
	int          n_fail, n_checks;
	fetch_execute_pkg::region_t fetch_region;
	localparam logic [3:0] ph1 = 4'h8, ph2 = 4'h4, ph3 = 4'h2, ph4 = 4'h1;

	assign primary_osc_pin = crystal_osc_mode ? osc_wave : btn;

	fetch_execute_sequencer fetch_execute_sequencer_i (.mclk, .rstn, .master_clear_n, .crystal_osc_mode,
		.internal_osc_tick, .primary_osc_pin, .gpio_out_level, .secondary_osc_pin, .push_button_input,
		.push_button_irq, .phase_one, .phase_two, .phase_three, .phase_four, .prog_addr, .prog_data, .fetch_region,
		.calib_fetch_blocked, .instruction_latch, .exec_valid, .operand_read_en, .dest_write_en, .pc, .branch_take,
		.branch_target, .irq_request, .irq_ack);
	prog_memory_model prog_memory_model_i (.mclk, .rstn, .prog_addr, .prog_data, .osc_tick(internal_osc_tick),
		.osc_wave);

	////////////////////////////////////////////////////////////////////////////////
	task final_report;
		$display("checks %0d errors %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report

	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// bounded wait for a phase; a hang ends the run
	task wait_ph(input logic [3:0] want);
		int i;
		for (i = 0; i < 40 && {phase_one, phase_two, phase_three, phase_four} !== want; i++)
			@(negedge mclk);
		if (i == 40)
		begin
			n_fail++;
			final_report();
		end
	endtask : wait_ph

	task chk_rst;
		chk("phase one", 1, phase_one);
		chk("addr", 0, prog_addr);
		chk("pc", 1, pc);
		chk("valid", 0, exec_valid);
	endtask : chk_rst

	////////////////////////////////////////////////////////////////////////////////
	task t_straight;
		logic [11:0] a;
		wait_ph(ph3);
		wait_ph(ph4);
		a = prog_addr;
		wait_ph(ph1);
		chk("latch", {2'b01, a}, instruction_latch);
		chk("valid", 1, exec_valid);
		chk("addr", a + 12'h001, prog_addr);
		chk("pc", {1'b0, a} + 13'h0002, pc);
		wait_ph(ph2);
		chk("read", 1, operand_read_en);
		chk("write", 0, dest_write_en);
		wait_ph(ph4);
		chk("write", 1, dest_write_en);
		chk("read", 0, operand_read_en);
	endtask : t_straight

	task t_jump(input logic [12:0] tgt, input logic use_irq);
		wait_ph(ph3);
		wait_ph(ph4);
		branch_take = !use_irq;
		branch_target = tgt;
		irq_request = use_irq;
		wait_ph(ph1);
		branch_take = 1'b0;
		irq_request = 1'b0;
		chk("ack", use_irq, irq_ack);
		chk("jump addr", tgt[11:0], prog_addr);
		chk("flush", 0, exec_valid);
		@(negedge mclk);
		chk("ack", 0, irq_ack);
		wait_ph(ph2);
		chk("flush read", 0, operand_read_en);
		wait_ph(ph4);
		chk("flush write", 0, dest_write_en);
		wait_ph(ph1);
		chk("target", {2'b01, tgt[11:0]}, instruction_latch);
		chk("valid", 1, exec_valid);
	endtask : t_jump

	task t_calib;
		wait_ph(ph3);
		wait_ph(ph4);
		branch_take = 1'b1;
		branch_target = 13'h0fc0;
		wait_ph(ph1);
		branch_take = 1'b0;
		chk("region", fetch_execute_pkg::REG_CALIB, fetch_region);
		wait_ph(ph2);
		chk("blocked", 1, calib_fetch_blocked);
		repeat (2)
		begin
			wait_ph(ph4);
			wait_ph(ph1);
		end
		chk("calib run", 0, exec_valid);
	endtask : t_calib

	task t_pins;
		int i;
		crystal_osc_mode = 1'b1;
		wait_ph(ph3);
		@(negedge mclk);
		chk("clock out", 1, secondary_osc_pin);
		chk("button", 1, push_button_input);
		wait_ph(ph1);
		@(negedge mclk);
		chk("clock out", 0, secondary_osc_pin);
		crystal_osc_mode = 1'b0;
		gpio_out_level = 1'b1;
		@(negedge mclk);
		btn = 1'b0;
		@(negedge mclk);
		chk("gpio", 1, secondary_osc_pin);
		chk("button", 0, push_button_input);
		for (i = 0; i < 4 && push_button_irq !== 1'b1; i++)
			@(negedge mclk);
		chk("button irq", 1, push_button_irq);
		@(negedge mclk);
		chk("button irq", 0, push_button_irq);
		btn = 1'b1;
	endtask : t_pins

	task t_clear;
		master_clear_n = 1'b0;
		repeat (8) @(negedge mclk);
		chk_rst();
		master_clear_n = 1'b1;
		wait_ph(ph4);
		wait_ph(ph1);
		chk("restart", 14'h1000, instruction_latch);
		chk("valid", 1, exec_valid);
	endtask : t_clear

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	initial
	begin
		n_fail = 0;
		n_checks = 0;
		rstn = 1'b0;
		master_clear_n = 1'b1;
		crystal_osc_mode = 1'b0;
		btn = 1'b1;
		gpio_out_level = 1'b0;
		branch_take = 1'b0;
		branch_target = 13'h0000;
		irq_request = 1'b0;
		repeat (20) @(negedge mclk);
		chk_rst();
		rstn = 1'b1;
		wait_ph(ph4);
		wait_ph(ph1);
		t_straight();
		t_jump(13'h1805, 1'b0);
		chk("region", fetch_execute_pkg::REG_PAGE1, fetch_region);
		t_jump(13'h0004, 1'b1);
		chk("region", fetch_execute_pkg::REG_PAGE0, fetch_region);
		t_straight();
		t_pins();
		t_calib();
		t_clear();
		final_report();
	end
endmodule : test_fetch_execute_sequencer
